// [incdec_pkg.sv]
// incdec_pkg: opcodes, field positions and widths for the inc/dec/skip/branch/or group
// assumes 14-bit instruction words of the enhanced midrange encoding
package incdec_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int INSN_W = 14;
	localparam int PC_W = 15;
	localparam int LIT11_W = 11;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DEST_BIT = 7;
	localparam int LATCH_LO = 3;
	localparam int LATCH_HI = 4;
	localparam int PC_HI_LO = 11;
	localparam int PC_HI_HI = 12;

	// ----------------------------------------------------------------
	// opcode patterns (upper six bits, branch upper three, unless noted)
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_DECREMENT_FILE = 6'h03;
	localparam logic [5:0] OP_DECREMENT_SKIP_ZERO = 6'h0B;
	localparam logic [5:0] OP_INCREMENT_FILE = 6'h0A;
	localparam logic [5:0] OP_INCREMENT_SKIP_ZERO = 6'h0F;
	localparam logic [5:0] OP_OR_LITERAL_ACCUMULATOR = 6'h38;
	localparam logic [2:0] OP_UNCONDITIONAL_BRANCH = 3'h5;
	// clear_accumulator: 00 0001 0xxx xxxx, upper seven bits
	localparam logic [6:0] OP_CLEAR_ACCUMULATOR = 7'h02;

	// ----------------------------------------------------------------
	// reset values and step constants
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

	// decoded operation kinds
	typedef enum logic [7:0] {
		K_NONE = 8'b0000_0001,
		K_DEC = 8'b0000_0010,
		K_INC = 8'b0000_0100,
		K_DECSKIP = 8'b0000_1000,
		K_INCSKIP = 8'b0001_0000,
		K_CLRACC = 8'b0010_0000,
		K_ORLIT = 8'b0100_0000,
		K_BRANCH = 8'b1000_0000
	} op_kind_t;
endpackage : incdec_pkg

// [incdec_decode.sv]
// incdec_decode: combinational decoder from instruction word to operation kind
// assumes the instruction word is stable for the whole instruction cycle
`timescale 1ns/1ns
`default_nettype none
module incdec_decode
	import incdec_pkg::*;
(
	// instruction in
	input wire logic [INSN_W-1:0] insn,
	// decoded kind out
	output op_kind_t kind
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// branch needs only three bits, so it is tested before the six-bit forms
	always_comb
	begin
		kind = K_NONE;
		if (insn[INSN_W-1 -: 3] == OP_UNCONDITIONAL_BRANCH)
			kind = K_BRANCH;
		else if (insn[INSN_W-1 -: 7] == OP_CLEAR_ACCUMULATOR)
			kind = K_CLRACC;
		else if (insn[INSN_W-1 -: 6] == OP_DECREMENT_FILE)
			kind = K_DEC;
		else if (insn[INSN_W-1 -: 6] == OP_INCREMENT_FILE)
			kind = K_INC;
		else if (insn[INSN_W-1 -: 6] == OP_DECREMENT_SKIP_ZERO)
			kind = K_DECSKIP;
		else if (insn[INSN_W-1 -: 6] == OP_INCREMENT_SKIP_ZERO)
			kind = K_INCSKIP;
		else if (insn[INSN_W-1 -: 6] == OP_OR_LITERAL_ACCUMULATOR)
			kind = K_ORLIT;
	end
endmodule : incdec_decode
`default_nettype wire

// [incdec_skip_branch_or_exec.sv]
// incdec_skip_branch_or_exec: executes the inc/dec, skip, branch and or-literal group
// assumes fetch presents one instruction per insn_valid pulse and file data is read
// combinationally from file_rdata for the operand field insn[6:0]; file_addr is
// the registered write address that goes out with file_we
//
// Operation
// - decrement file, destination bit picks target, zero flag
// - clear accumulator, zero flag set
// - decrement and skip, flags left unchanged
// - zero result turns next instruction into nop
// - increment and skip, flags kept, skip on zero
// - branch loads literal and latch bits into pc
// - branch takes two cycles, flushes fetched word
// - or literal into accumulator, zero flag
// - increment file, destination bit picks target, zero flag
`timescale 1ns/1ns
`default_nettype none
module incdec_skip_branch_or_exec
	import incdec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// instruction cycle enable and instruction word
	input wire logic insn_valid,
	input wire logic [INSN_W-1:0] insn,
	// data file and latch
	input wire logic [DATA_W-1:0] file_rdata,
	input wire logic [DATA_W-1:0] upper_address_latch,
	output logic [ADDR_W-1:0] file_addr,
	output logic [DATA_W-1:0] file_wdata,
	output logic file_we,
	// core state
	output logic [DATA_W-1:0] accumulator,
	output logic zero_flag,
	output logic zero_flag_we,
	output logic [PC_W-1:0] pc,
	output logic flush
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	op_kind_t kind;
	logic [DATA_W-1:0] acc_r;
	logic zf_r;
	logic zf_we_r;
	logic [PC_W-1:0] pc_r;
	logic [ADDR_W-1:0] faddr_r;
	logic [DATA_W-1:0] fwdata_r;
	logic fwe_r;
	logic flush_r;
	logic [DATA_W-1:0] incdec_nxt;
	logic [DATA_W-1:0] or_nxt;
	logic to_file;
	logic result_zero;
	logic [PC_W-1:0] branch_nxt;

	incdec_decode u_decode
	(
		.insn(insn),
		.kind(kind)
	);

	// zero test shared by flag and skip decisions
	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		is_zero = (v == ZERO_BYTE);
	endfunction : is_zero

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	// addition is cut to eight bits on purpose so 00h-1 gives ffh
	always_comb
	begin
		unique case (kind)
			K_DEC, K_DECSKIP: incdec_nxt = DATA_W'(file_rdata - ONE_BYTE);
			K_INC, K_INCSKIP: incdec_nxt = DATA_W'(file_rdata + ONE_BYTE);
			default: incdec_nxt = file_rdata;
		endcase
	end
	assign or_nxt = acc_r | insn[DATA_W-1:0];
	assign to_file = insn[DEST_BIT];
	assign result_zero = is_zero(incdec_nxt);
	// paged target: literal low bits, latch bits above, rest left clear
	assign branch_nxt = {{(PC_W-PC_HI_HI-1){1'b0}},
		upper_address_latch[LATCH_HI:LATCH_LO], insn[LIT11_W-1:0]};

	// write address, registered with the write strobe: a write lands one edge after
	// its instruction, so a word that reads the same cell next sees the old value
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			faddr_r <= '0;
		else
			faddr_r <= insn[ADDR_W-1:0];
	end

	// ----------------------------------------------------------------
	// execution, one process per concern
	// ----------------------------------------------------------------
	// flush pulse: the cycle after a branch or a taken skip runs as a nop
	// a flushed word never re-arms flush, so a branch under a skip is dropped too
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			flush_r <= 1'b0;
		else if (insn_valid)
		begin
			if (flush_r)
				flush_r <= 1'b0; // second cycle, discarded word consumed
			else if (kind == K_BRANCH)
				flush_r <= 1'b1;
			else if ((kind == K_DECSKIP || kind == K_INCSKIP) && result_zero)
				flush_r <= 1'b1;
			else
				flush_r <= 1'b0;
		end
	end

	// accumulator writes
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			acc_r <= ACC_RESET;
		else if (insn_valid && !flush_r)
		begin
			unique case (kind)
				K_DEC, K_INC, K_DECSKIP, K_INCSKIP:
					if (!to_file)
						acc_r <= incdec_nxt;
				K_CLRACC: acc_r <= ZERO_BYTE;
				K_ORLIT: acc_r <= or_nxt;
				default: acc_r <= acc_r;
			endcase
		end
	end

	// file register write-back, a one-cycle strobe
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fwe_r <= 1'b0;
			fwdata_r <= ZERO_BYTE;
		end
		else
		begin
			fwe_r <= 1'b0;
			if (insn_valid && !flush_r && to_file &&
				(kind == K_DEC || kind == K_INC || kind == K_DECSKIP || kind == K_INCSKIP))
			begin
				fwe_r <= 1'b1;
				fwdata_r <= incdec_nxt;
			end
		end
	end

	// zero flag; skip forms and branch never touch it
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			zf_r <= 1'b0;
			zf_we_r <= 1'b0;
		end
		else
		begin
			zf_we_r <= 1'b0;
			if (insn_valid && !flush_r)
			begin
				unique case (kind)
					K_DEC, K_INC:
					begin
						zf_r <= result_zero;
						zf_we_r <= 1'b1;
					end
					K_CLRACC:
					begin
						zf_r <= 1'b1;
						zf_we_r <= 1'b1;
					end
					K_ORLIT:
					begin
						zf_r <= is_zero(or_nxt);
						zf_we_r <= 1'b1;
					end
					default: zf_r <= zf_r;
				endcase
			end
		end
	end

	// program counter: branch loads target, everything else steps by one
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pc_r <= PC_RESET;
		else if (insn_valid)
		begin
			if (!flush_r && kind == K_BRANCH)
				pc_r <= branch_nxt;
			else
				pc_r <= PC_W'(pc_r + PC_STEP);
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign accumulator = acc_r;
	assign zero_flag = zf_r;
	assign zero_flag_we = zf_we_r;
	assign pc = pc_r;
	assign flush = flush_r;
	assign file_addr = faddr_r;
	assign file_wdata = fwdata_r;
	assign file_we = fwe_r;
endmodule : incdec_skip_branch_or_exec
`default_nettype wire

// [incdec_exec_sva.sv]
// incdec_exec_sva: port assertions for the inc/dec, skip, branch and or-literal block
// assumes it is bound to incdec_skip_branch_or_exec on one clock
`timescale 1ns/1ns
`default_nettype none
module incdec_exec_sva
	import incdec_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic reset_n,
	input wire logic insn_valid,
	input wire logic [13:0] insn,
	input wire logic [7:0] file_rdata,
	input wire logic [7:0] upper_address_latch,
	input wire logic [7:0] file_wdata,
	input wire logic file_we,
	input wire logic [7:0] accumulator,
	input wire logic zero_flag,
	input wire logic zero_flag_we,
	input wire logic [14:0] pc,
	input wire logic flush
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// a word taken while flushed is a nop, so every decode is gated
	wire logic tk = insn_valid && !flush;
	wire logic [5:0] op = insn[13:8];
	wire logic [1:0] pg = upper_address_latch[4:3];
	wire logic [10:0] lit = insn[10:0];
	wire logic [7:0] lit8 = insn[7:0];
	property p_dec; tk && insn[13:7] == 7'h07 |=> file_we && file_wdata == $past(file_rdata) - 8'h01
		&& zero_flag_we && zero_flag == (file_wdata == 8'h00); endproperty
	a_dec: assert property (p_dec) else $error("dec to file");
	property p_inc; tk && insn[13:7] == 7'h14 |=> !file_we && accumulator == $past(file_rdata) + 8'h01
		&& zero_flag == (accumulator == 8'h00); endproperty
	a_inc: assert property (p_inc) else $error("inc to acc");
	property p_clr; tk && insn[13:7] == 7'h02 |=> accumulator == 8'h00 && zero_flag && zero_flag_we; endproperty
	a_clr: assert property (p_clr) else $error("clear acc");
	property p_keep; tk && (op == 6'h0b || op == 6'h0f) |=> !zero_flag_we; endproperty
	a_keep: assert property (p_keep) else $error("skip touched flag");
	property p_skip; tk && op == 6'h0b |=> flush == ($past(file_rdata) == 8'h01); endproperty
	a_skip: assert property (p_skip) else $error("dec skip");
	property p_incskip; tk && op == 6'h0f |=> flush == ($past(file_rdata) == 8'hff); endproperty
	a_incskip: assert property (p_incskip) else $error("inc skip");
	property p_br; tk && insn[13:11] == 3'h5 |=> flush && pc == {2'b00, $past(pg), $past(lit)}; endproperty
	a_br: assert property (p_br) else $error("branch target");
	property p_or; tk && op == 6'h38 |=> accumulator == ($past(accumulator) | $past(lit8)); endproperty
	a_or: assert property (p_or) else $error("or literal");
	property p_nop; insn_valid && flush |=> pc == $past(pc) + 15'h0001 && !file_we && !flush; endproperty
	a_nop: assert property (p_nop) else $error("flushed word");
	property p_step; tk && (op == 6'h03 || op == 6'h38) |=> !flush && pc == $past(pc) + 15'h0001; endproperty
	a_step: assert property (p_step) else $error("single step");
endmodule : incdec_exec_sva
bind incdec_skip_branch_or_exec incdec_exec_sva incdec_exec_sva_inst (.*);
`default_nettype wire

// [file_model.sv]
// file_model: data file registers on the far side of the exec block
// assumes reads follow insn[6:0] combinationally and writes land on file_we
`timescale 1ns/1ns
`default_nettype none
module file_model
	import incdec_pkg::*;
(
	// read and write side
	input wire logic clk,
	input wire logic [INSN_W-1:0] insn,
	input wire logic [ADDR_W-1:0] file_addr,
	input wire logic [DATA_W-1:0] file_wdata,
	input wire logic file_we,
	output logic [DATA_W-1:0] file_rdata
);
	logic [DATA_W-1:0] mem [128];
	// cell holds its address minus one, so 00, 01 and ff all exist
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i - 1);
	// no forwarding: a write is seen from the following edge on
	always @(posedge clk) if (file_we) mem[file_addr] <= file_wdata;
	assign file_rdata = mem[insn[6:0]];
endmodule : file_model
`default_nettype wire

// [incdec_skip_branch_or_exec_tb.sv]
// incdec_skip_branch_or_exec_tb: directed tests of the exec block
// assumes file_model as data file and one word taken per edge
`timescale 1ns/1ns
`default_nettype none
module incdec_skip_branch_or_exec_tb
	import incdec_pkg::*;
;
	logic clk, reset_n, insn_valid, file_we, zero_flag, zero_flag_we, flush;
	logic [INSN_W-1:0] insn;
	logic [DATA_W-1:0] file_rdata, upper_address_latch, file_wdata, accumulator;
	logic [ADDR_W-1:0] file_addr;
	logic [PC_W-1:0] pc, p;
	int miscompares = 0;
	int num_checks = 0;
	incdec_skip_branch_or_exec incdec_skip_branch_or_exec_inst (.*);
	file_model file_model_inst (.*);
	// 50 ns clock
	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// drive a word; at the negedge the outputs show the word driven one call earlier
	task automatic run(input logic [13:0] w);
		@(posedge clk);
		insn <= w;
		@(negedge clk);
	endtask : run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t ns: %s", $time, m);
		end
	endtask : chk
	task automatic t_incdec;
		run(14'h0381); run(0); chk({file_we, file_wdata, zero_flag}, {9'h1ff, 1'b0}, "dec");
		chk(file_addr, 7'h01, "dec address");
		run(14'h0302); run(0); chk({file_we, accumulator, zero_flag}, 10'h001, "dec acc");
		run(14'h0a00); run(0); chk({accumulator, zero_flag, zero_flag_we}, 10'h003, "inc");
		p = pc;
		run(14'h0a85); run(0); chk({file_wdata, flush, pc}, {8'h05, 1'b0, p + 15'h2}, "inc f");
		$display("inc dec done");
	endtask : t_incdec
	task automatic t_orclr;
		run(14'h385a); run(14'h0100); chk({accumulator, zero_flag}, 9'h0b4, "or");
		run(14'h3800); chk({accumulator, zero_flag, zero_flag_we}, 10'h003, "clear");
		run(14'h3881); chk({accumulator, zero_flag}, 9'h001, "or zero");
		run(0); chk({accumulator, zero_flag}, 9'h102, "or 81");
		$display("or clear done");
	endtask : t_orclr
	task automatic t_skip;
		run(14'h0b83); run(0); chk({file_wdata, flush, zero_flag_we}, 10'h004, "nonzero");
		run(14'h0b02); run(14'h38ff); chk({accumulator, flush}, 9'h001, "dec skip");
		run(0); chk({accumulator, flush}, 9'h000, "skipped word");
		run(14'h0f80); run(0); chk({file_we, file_wdata, flush}, 10'h201, "inc skip");
		run(14'h0f06); run(0); chk({accumulator, flush, zero_flag_we}, 10'h018, "inc keep");
		$display("skip done");
	endtask : t_skip
	task automatic br(input logic [7:0] l, input logic [10:0] k, input logic [14:0] t);
		@(posedge clk);
		upper_address_latch <= l;
		run({3'h5, k});
		run(14'h0100); chk({pc, flush}, {t, 1'b1}, "branch");
		run(0); chk({pc, flush, accumulator}, {t + 15'h1, 9'h006}, "flushed");
		$display("branch done");
	endtask : br
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// hang guard
	initial
	begin
		repeat (2000) @(posedge clk);
		miscompares++;
		end_of_test;
	end
	initial
	begin
		reset_n = 0;
		insn_valid = 0;
		insn = 0;
		upper_address_latch = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1;
		insn_valid <= 1;
		t_incdec;
		t_orclr;
		t_skip;
		br(8'h08, 11'h123, 15'h0923);
		br(8'hf7, 11'h7ff, 15'h17ff);
		end_of_test;
	end
endmodule : incdec_skip_branch_or_exec_tb
`default_nettype wire
